// ===== verilog/lhp_host_port.sv
// Host port of the display driver: parallel and serial intake and read-back.
// Assumes host pins already synchronous to ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
module lhp_host_port (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic init_clear_n_in,
  input wire logic par_select_in,
  input wire logic bus_style_select_in,
  input wire logic chip_select_n_in,
  input wire logic data_sel_in,
  input wire logic strobe_a_in,
  input wire logic strobe_b_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n_out,
  output logic [8:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic [7:0] rd_byte_in,
  output logic rd_req_out,
  output logic rd_is_data_out,
  output logic overflow_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset and strap
  logic clr;
  logic style_enable;
  logic strap_taken;
  assign clr = srst_in || !init_clear_n_in;
  // Strap caught once after reset release
  always_ff @(posedge ref_clk_in) begin
    if (clr) begin
      strap_taken <= 1'b0;
      style_enable <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      style_enable <= bus_style_select_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Parallel strobe decode
  logic sel;
  logic rd_act;
  logic wr_act;
  logic wr_act_q;
  logic rd_act_q;
  logic [7:0] wr_latch;
  logic wr_sel_latch;
  assign sel = !chip_select_n_in;
  // Enable style: high enable, direction chooses access
  assign rd_act = par_select_in && sel &&
    (style_enable ? (strobe_a_in && strobe_b_in) : !strobe_a_in);
  assign wr_act = par_select_in && sel &&
    (style_enable ? (strobe_a_in && !strobe_b_in) : !strobe_b_in);
  // Track active strobes and latch write data during active phase
  always_ff @(posedge ref_clk_in) begin
    if (clr) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_latch <= lhp_pkg::BYTE_RST;
      wr_sel_latch <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        wr_latch <= data_in;
        wr_sel_latch <= data_sel_in;
      end
    end
  end
  // Write ends on the strobe's rising edge (or enable falling)
  logic par_wr_done;
  assign par_wr_done = wr_act_q && !wr_act;
  ////////////////////////////////////////////////////////////////////////////
  // Serial intake on data bit 6 clock, bit 7 data
  logic sclk_q;
  logic [2:0] ser_cnt;
  logic [6:0] ser_sh;
  logic ser_rise;
  logic ser_done;
  logic [7:0] ser_byte;
  assign ser_rise = !par_select_in && sel && data_in[6] && !sclk_q;
  assign ser_done = ser_rise && (ser_cnt == 3'(lhp_pkg::SER_BITS - 1));
  assign ser_byte = {ser_sh, data_in[7]};
  // Shift MSB first; chip select high restarts the byte
  always_ff @(posedge ref_clk_in) begin
    if (clr) begin
      sclk_q <= 1'b1;
      ser_cnt <= lhp_pkg::SER_CNT_RST;
      ser_sh <= 7'h00;
    end else begin
      sclk_q <= data_in[6];
      if (!sel || par_select_in) begin
        ser_cnt <= lhp_pkg::SER_CNT_RST;
      end else if (ser_rise) begin
        ser_cnt <= ser_cnt + 3'h1;
        ser_sh <= {ser_sh[5:0], data_in[7]};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Byte into FIFO, selector tagged with each byte
  lhp_pkg::lhp_byte_t in_byte;
  logic in_valid;
  logic in_ready;
  assign in_valid = par_wr_done || ser_done;
  assign in_byte.is_data = ser_done ? data_sel_in : wr_sel_latch;
  assign in_byte.value = ser_done ? ser_byte : wr_latch;
  lhp_fifo #(.WIDTH(lhp_pkg::BYTE_W), .DEPTH(lhp_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .srst_in(clr),
    .wr_data_in(in_byte),
    .wr_valid_in(in_valid),
    .wr_ready_out(in_ready),
    .rd_data_out(rx_data_out),
    .rd_valid_out(rx_valid_out),
    .rd_ready_in(rx_ready_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Read-back drive and status outputs
  logic [7:0] next_oe_n;
  assign next_oe_n = (rd_act && par_select_in) ? lhp_pkg::OE_ON : lhp_pkg::OE_OFF;
  always_ff @(posedge ref_clk_in) begin
    if (clr) begin
      data_out <= lhp_pkg::BYTE_RST;
      data_oe_n_out <= lhp_pkg::OE_OFF;
      rd_req_out <= 1'b0;
      rd_is_data_out <= 1'b0;
      overflow_out <= 1'b0;
    end else begin
      data_out <= rd_byte_in;
      data_oe_n_out <= next_oe_n;
      rd_req_out <= rd_act && !rd_act_q;
      rd_is_data_out <= data_sel_in;
      if (in_valid && !in_ready) overflow_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/lhp_pkg.sv
// Constants and carriers for the display driver host port.
// Assumes one 40 MHz clock and synchronous active-high reset.
//
// Behaviour
// - Eight-bit two-way parallel data port
// - Serial select low: bit7 data, bit6 clock
// - Chip select inactive: all data lines float
// - Separate strobes: read low drives bus
// - Enable style: high enable qualifies access
// - Separate strobes: write captured on rising edge
// - Direction high reads, low writes
// - Selector high display data, low control
// - Transfers only while chip select low
// - Reset pin low clears all settings
// - Strobe effective only with chip select low
package lhp_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SER_BITS = 8;
  localparam logic [2:0] SER_CNT_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] OE_OFF = 8'hff;
  localparam logic [7:0] OE_ON = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;
  localparam logic BIT_SER = 1'b0;
  localparam logic BIT_DATA = 1'b1;
  // Byte taken from the host with its data/command flag
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } lhp_byte_t;
  localparam int BYTE_W = $bits(lhp_byte_t);
endpackage

// ===== verilog/lhp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module lhp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = wr_valid_in && wr_ready_out;
  wire pop = rd_valid_out && rd_ready_in;
  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  // Storage
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
  // Pointers and occupancy
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/lhp_host_port_asserts.sv
// Checker on the host port pins: bus drive, reset, read pulse.
// Bound to every lhp_host_port instance.
`timescale 1ns/10ps
`default_nettype none
module lhp_host_port_asserts (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic init_clear_n_in,
  input wire logic par_select_in,
  input wire logic chip_select_n_in,
  input wire logic [7:0] data_oe_n_out,
  input wire logic rx_valid_out,
  input wire logic rd_req_out,
  input wire logic overflow_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in || !init_clear_n_in);
  // Bus drive and its causes
  oe_whole_a: assert property (data_oe_n_out == 8'h00 || data_oe_n_out == 8'hff) else $error("oe split");
  cs_float_a: assert property ($past(chip_select_n_in) |-> data_oe_n_out == 8'hff) else $error("oe no cs");
  ser_float_a: assert property ($past(!par_select_in) |-> data_oe_n_out == 8'hff) else $error("oe ser");
  oe_cause_a: assert property (data_oe_n_out != 8'hff |-> $past(!chip_select_n_in)) else $error("oe");
  rd_drive_a: assert property (rd_req_out |-> data_oe_n_out == 8'h00) else $error("rd oe");
  rd_pulse_a: assert property (rd_req_out |=> !rd_req_out) else $error("rd pulse");
  // Reset pin clears, overflow holds until then
  clr_idle_a: assert property (disable iff (srst_in) !init_clear_n_in |=> !rx_valid_out && !overflow_out
    && data_oe_n_out == 8'hff) else $error("clear");
  ovf_hold_a: assert property (overflow_out |=> overflow_out) else $error("ovf");
endmodule
bind lhp_host_port lhp_host_port_asserts u_lhp_host_port_asserts (.*);
`default_nettype wire

// ===== dv/lhp_host_model.sv
// Host model: selects, strobes and bus value.
// Bench merges hbus_out with the device drive into bus_in.
`timescale 1ns/10ps
`default_nettype none
module lhp_host_model (
  input wire logic ref_clk_in,
  input wire logic style_in,
  input wire logic [7:0] bus_in,
  output logic cs_n_out,
  output logic dsel_out,
  output logic sa_out,
  output logic sb_out,
  output logic [7:0] hbus_out
);
  logic r = 0, w = 0, hen = 0;
  logic [7:0] hv = 8'h00, last = 8'h00;
  // Strobes per style; a released bus shows its last level inverted
  assign sa_out = style_in ? r | w : !r;
  assign sb_out = !w;
  assign hbus_out = hen ? hv : ~last;
  always @(posedge ref_clk_in) last <= hbus_out;
  initial {cs_n_out, dsel_out} = 2'b10;
  task automatic t(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // One access held three cycles
  task automatic acc(input logic c, rd, dc, input logic [7:0] b, output logic [7:0] v);
    {cs_n_out, dsel_out, hv, hen, r, w} = {c, dc, b, !rd, rd, !rd};
    t(3);
    {v, r, w} = {bus_in, 2'b00};
    t(1);
    {cs_n_out, hen} = 2'b10;
    t(1);
  endtask
  // Serial byte, clock phases of two cycles
  task automatic ser(input logic dc, input logic [7:0] b);
    {cs_n_out, dsel_out, hen} = {1'b0, dc, 1'b1};
    for (int j = 0; j < 16; j++) begin
      hv = {b[7 - j / 2], j[0], 6'h00};
      t(2);
    end
    hv = 8'h00;
    t(2);
    {cs_n_out, hen} = 2'b10;
    t(1);
  endtask
endmodule
`default_nettype wire

// ===== dv/lhp_host_port_test.sv
// Bench: accesses, overflow, serial, both styles.
// Host model drives the pins.
`timescale 1ns/10ps
`default_nettype none
module lhp_host_port_test;
  logic clk = 0, srst = 1, ic_n = 1, psel = 1, style = 0, rdy = 0;
  logic cs_n, dsel, sa, sb, rxv, ovf, rdreq, rdisd;
  int rd_reqs = 0;
  logic [7:0] bus, hbus, dout, oe_n, v, rdb = 8'h3c;
  logic [8:0] rx;
  int num_errors = 0, check_count = 0;
  // Clock; a bit with low enable carries the device value
  always #12.5 clk = ~clk;
  assign bus = ~oe_n & dout | oe_n & hbus;
  // Count read request pulses from the device
  always @(posedge clk) if (rdreq === 1'b1) rd_reqs++;
  lhp_host_port u_lhp_host_port (.ref_clk_in(clk), .srst_in(srst), .init_clear_n_in(ic_n), .par_select_in(psel),
    .bus_style_select_in(style), .chip_select_n_in(cs_n), .data_sel_in(dsel), .strobe_a_in(sa), .strobe_b_in(sb),
    .data_in(bus), .data_out(dout), .data_oe_n_out(oe_n), .rx_data_out(rx), .rx_valid_out(rxv), .rx_ready_in(rdy),
    .rd_byte_in(rdb), .rd_req_out(rdreq), .rd_is_data_out(rdisd), .overflow_out(ovf));
  lhp_host_model u_lhp_host_model (.ref_clk_in(clk), .style_in(style), .bus_in(bus), .cs_n_out(cs_n),
    .dsel_out(dsel), .sa_out(sa), .sb_out(sb), .hbus_out(hbus));
  task automatic t(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [8:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rst(input logic s);
    {srst, style} = {1'b1, s};
    t(16);
    srst = 0;
    t(2);
    chk("idle", 9'h0ff, {rxv, oe_n});
  endtask
  task automatic pop(input logic [8:0] e);
    repeat (8) if (rxv !== 1'b1) t(1);
    chk("rx", e, rx);
    rdy = 1;
    t(1);
    rdy = 0;
    t(1);
  endtask
  // Command, unselected write, data, then a read
  task automatic s_acc;
    int n;
    n = rd_reqs;
    u_lhp_host_model.acc(0, 0, 0, 8'h5a, v);
    u_lhp_host_model.acc(1, 0, 1, 8'h77, v);
    u_lhp_host_model.acc(0, 0, 1, 8'ha5, v);
    pop(9'h05a);
    pop(9'h1a5);
    u_lhp_host_model.acc(0, 1, 1, 8'h00, v);
    chk("rd", {1'b0, rdb}, {rxv, v});
    chk("rdsel", 9'h001, {8'h00, rdisd});
    chk("rdreq", 9'h001, 9'(rd_reqs - n));
  endtask
  // Overrun while stalled, drain, clear
  task automatic s_fill;
    for (int i = 0; i < 17; i++) u_lhp_host_model.acc(0, 0, 1, 8'(i), v);
    for (int i = 0; i < 16; i++) pop({1'b1, 8'(i)});
    u_lhp_host_model.acc(0, 0, 1, 8'h11, v);
    chk("ovf", 9'h003, {7'h00, ovf, rxv});
    ic_n = 0;
    t(1);
    ic_n = 1;
    t(2);
    chk("clr", 9'h000, {7'h00, ovf, rxv});
  endtask
  task automatic s_ser;
    psel = 0;
    u_lhp_host_model.ser(1, 8'hc3);
    u_lhp_host_model.ser(0, 8'h81);
    pop(9'h1c3);
    pop(9'h081);
    psel = 1;
  endtask
  // Main sequence and watchdog
  initial begin
    rst(0);
    s_acc;
    s_fill;
    s_ser;
    rst(1);
    s_acc;
    end_of_test;
  end
  initial begin
    t(3000);
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
